//--- core/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// converter resolution and channel count
`define DCC_RES             14
`define DCC_CHANNELS        16
`define DCC_ADDR_BITS       4
`define DCC_WORD_BITS       24
`define DCC_CNT_BITS        5
`define DCC_WORD_LAST       5'd23

// coefficient reset values and arithmetic anchors
`define DCC_GAIN_RESET      14'h3ffe
`define DCC_OFFSET_RESET    14'h2000
`define DCC_CODE_RESET      14'h0000
`define DCC_CODE_MAX        14'h3fff
`define DCC_GAIN_BIAS       15'h0002
`define DCC_OFFSET_ZERO     17'sh02000

// system-side synchroniser lanes
`define DCC_SYNC_LANES      5
`define DCC_SYNC_RESET      5'h08
`define DCC_LANE_FULL       0
`define DCC_LANE_CHAIN      1
`define DCC_LANE_SPI        2
`define DCC_LANE_LOAD_N     3
`define DCC_LANE_DONE       4

`endif

//--- core/dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [1:0] {
        DCC_SEL_SPECIAL = 2'h0,
        DCC_SEL_GAIN    = 2'h1,
        DCC_SEL_OFFSET  = 2'h2,
        DCC_SEL_INPUT   = 2'h3
    } dcc_reg_sel_t;

    // 24-bit serial command, msb first on the wire
    typedef struct packed {
        logic         bank;
        logic         read_flag;
        logic [1:0]   zeros;
        logic [3:0]   channel_addr;
        dcc_reg_sel_t reg_select;
        logic [13:0]  data;
    } dcc_cmd_t;

    // per-channel calibration state
    typedef struct packed {
        logic [13:0] gain;
        logic [13:0] offset;
        logic [13:0] pending;
        logic [13:0] active;
    } dcc_chan_t;

endpackage : dcc_pkg

//--- core/dcc_top.sv
`timescale 1ns/1ps
`include "dcc_params.svh"

module dcc_top (
    // system clock and reset
    input  wire logic                                    i_clock,
    input  wire logic                                    i_rst,
    // serial link from the host
    input  wire logic                                    i_link_clock,
    input  wire logic                                    i_frame_select_n,
    input  wire logic                                    i_serial_data,
    output logic                                         o_chain_shift_out,
    // configuration and strobe pins
    input  wire logic                                    i_interface_select,
    input  wire logic                                    i_chain_enable_pin,
    input  wire logic                                    i_load_outputs_strobe_n,
    // converter codes and status
    output logic [`DCC_CHANNELS-1:0][`DCC_RES-1:0]       o_dac_code,
    output logic                                         o_write_accepted
);

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift register and bit counter on the falling link clock edge

    logic [`DCC_WORD_BITS-1:0] shift_reg;
    logic [`DCC_CNT_BITS-1:0]  bit_cnt_reg;
    logic                      word_full_reg;
    logic                      shift_en;
    logic                      done_tog_reg;
    logic                      word_last;

    // frame high holds the counter cleared, so nothing toggles between frames
    // strap pins are read raw here: they are tied, and the link clock stops between frames
    assign shift_en = i_interface_select
                    & (i_chain_enable_pin | ~word_full_reg);

    always_ff @(negedge i_link_clock or posedge i_frame_select_n)
    begin
        if (i_frame_select_n)
        begin
            bit_cnt_reg   <= '0;
            word_full_reg <= 1'b0;
        end
        else if (shift_en && !word_full_reg)
        begin
            bit_cnt_reg   <= bit_cnt_reg + 5'd1;
            word_full_reg <= (bit_cnt_reg == `DCC_WORD_LAST);
        end
    end

    always_ff @(negedge i_link_clock)
    begin
        if (!i_frame_select_n && shift_en)
        begin
            shift_reg <= {shift_reg[`DCC_WORD_BITS-2:0], i_serial_data};
        end
    end

    // the 24th bit in standalone flips a toggle that frame high cannot clear,
    // so a frame closed right after its last bit still reaches the commit
    assign word_last = shift_en & ~word_full_reg & (bit_cnt_reg == `DCC_WORD_LAST);

    always_ff @(negedge i_link_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_tog_reg <= 1'b0;
        end
        else if (!i_frame_select_n && word_last && !i_chain_enable_pin)
        begin
            done_tog_reg <= ~done_tog_reg;
        end
    end

    // chain output launches on the rising edge, valid at the next falling one
    always_ff @(posedge i_link_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_chain_shift_out <= 1'b0;
        end
        else
        begin
            o_chain_shift_out <= i_chain_enable_pin & shift_reg[`DCC_WORD_BITS-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system domain: pin synchronisers and word completion

    logic [`DCC_SYNC_LANES-1:0] sync1_reg;
    logic [`DCC_SYNC_LANES-1:0] sync2_reg;
    logic                       full_prev_reg;
    logic                       done_prev_reg;
    logic [`DCC_SYNC_LANES-1:0] pin_raw;

    assign pin_raw[`DCC_LANE_FULL]   = word_full_reg;
    assign pin_raw[`DCC_LANE_CHAIN]  = i_chain_enable_pin;
    assign pin_raw[`DCC_LANE_SPI]    = i_interface_select;
    assign pin_raw[`DCC_LANE_LOAD_N] = i_load_outputs_strobe_n;
    assign pin_raw[`DCC_LANE_DONE]   = done_tog_reg;

    // every pin and link flag passes two flops before the system logic reads it
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sync1_reg <= `DCC_SYNC_RESET;
            sync2_reg <= `DCC_SYNC_RESET;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // previous values for the edge detectors, reset to the lanes' idle levels
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            full_prev_reg <= 1'b0;
            done_prev_reg <= 1'b0;
        end
        else
        begin
            full_prev_reg <= sync2_reg[`DCC_LANE_FULL];
            done_prev_reg <= sync2_reg[`DCC_LANE_DONE];
        end
    end

    logic full_s;
    logic chain_s;
    logic spi_s;
    logic load_s;
    logic done_s;
    logic done_step;
    logic full_fall;
    logic commit;

    assign full_s    = sync2_reg[`DCC_LANE_FULL];
    assign chain_s   = sync2_reg[`DCC_LANE_CHAIN];
    assign spi_s     = sync2_reg[`DCC_LANE_SPI];
    assign load_s    = ~sync2_reg[`DCC_LANE_LOAD_N];
    assign done_s    = sync2_reg[`DCC_LANE_DONE];
    assign done_step = done_s ^ done_prev_reg;
    assign full_fall = ~full_s & full_prev_reg;

    // standalone takes the word at its 24th bit, chain mode when the frame closes;
    // a short frame never sets full and is dropped; the word is frozen at both points
    assign commit = spi_s & (chain_s ? full_fall : done_step);

    ////////////////////////////////////////////////////////////////////////////////
    // command decode

    dcc_pkg::dcc_cmd_t cmd;
    logic              is_write;
    logic              wr_input;
    logic              wr_offset;
    logic              wr_gain;

    // the word crosses without a synchroniser: it stands still from the
    // commit point until the first bit of the next frame
    assign cmd       = dcc_pkg::dcc_cmd_t'(shift_reg);
    assign is_write  = commit & ~cmd.read_flag & ~cmd.bank;
    assign wr_input  = is_write & (cmd.reg_select == dcc_pkg::DCC_SEL_INPUT);
    assign wr_offset = is_write & (cmd.reg_select == dcc_pkg::DCC_SEL_OFFSET);
    assign wr_gain   = is_write & (cmd.reg_select == dcc_pkg::DCC_SEL_GAIN);

    ////////////////////////////////////////////////////////////////////////////////
    // calibration arithmetic for the addressed channel

    // one record per channel: coefficients, pending code and converter code
    dcc_pkg::dcc_chan_t chan_reg [`DCC_CHANNELS];

    logic [`DCC_RES-1:0]   sel_gain;
    logic [`DCC_RES-1:0]   sel_offset;
    logic [`DCC_RES:0]     gain_plus;
    logic [2*`DCC_RES:0]   product;
    logic signed [16:0]    scaled;
    logic signed [16:0]    corrected;
    logic [`DCC_RES-1:0]   cal_code;
    logic                  below_zero;
    logic                  above_full;

    assign sel_gain   = chan_reg[cmd.channel_addr].gain;
    assign sel_offset = chan_reg[cmd.channel_addr].offset;
    // gain plus two never exceeds 2^n, so the scaled word fits n+1 bits
    assign gain_plus  = {1'b0, sel_gain} + `DCC_GAIN_BIAS;
    assign product    = gain_plus * cmd.data;
    assign scaled     = signed'({2'b00, product[2*`DCC_RES:`DCC_RES]});
    // offset is offset binary: subtracting mid-scale gives the signed trim
    assign corrected  = scaled + signed'({3'b000, sel_offset})
                      - `DCC_OFFSET_ZERO;
    // negative sums clamp to zero, sums past full scale to the top code
    assign below_zero = corrected[16];
    assign above_full = corrected > signed'({3'b000, `DCC_CODE_MAX});
    assign cal_code   = below_zero ? `DCC_CODE_RESET
                      : above_full ? `DCC_CODE_MAX
                      : corrected[`DCC_RES-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel coefficient, pending and active registers

    genvar ch;
    generate
        for (ch = 0; ch < `DCC_CHANNELS; ch++)
        begin : g_chan
            logic               hit;
            logic               take_gain;
            logic               take_offset;
            logic               take_input;
            dcc_pkg::dcc_chan_t chan_next;

            assign hit         = (cmd.channel_addr == `DCC_ADDR_BITS'(ch));
            assign take_gain   = hit & wr_gain;
            assign take_offset = hit & wr_offset;
            assign take_input  = hit & wr_input;

            // while the strobe stays low the converter code trails pending by a cycle

            always_comb
            begin
                chan_next = chan_reg[ch];
                if (take_gain)
                begin
                    chan_next.gain = {cmd.data[`DCC_RES-1:1], 1'b0};
                end
                if (take_offset)
                begin
                    chan_next.offset = cmd.data;
                end
                if (take_input)
                begin
                    chan_next.pending = cal_code;
                end
                if (load_s)
                begin
                    chan_next.active = chan_reg[ch].pending;
                end
            end

            always_ff @(posedge i_clock)
            begin
                if (i_rst)
                begin
                    chan_reg[ch] <= '{gain:    `DCC_GAIN_RESET,
                                      offset:  `DCC_OFFSET_RESET,
                                      pending: `DCC_CODE_RESET,
                                      active:  `DCC_CODE_RESET};
                end
                else
                begin
                    chan_reg[ch] <= chan_next;
                end
            end

            // each converter code is the active register itself
            assign o_dac_code[ch] = chan_reg[ch].active;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // status: one pulse per stored write, refused words leave it low

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_write_accepted <= 1'b0;
        end
        else
        begin
            o_write_accepted <= wr_input | wr_offset | wr_gain;
        end
    end

endmodule : dcc_top

//--- tb/dcc_host_model.sv
`timescale 1ns/1ps
module dcc_host_model (
    // link pins
    output logic      o_link_clock,
    output logic      o_frame_select_n,
    output logic      o_serial_data,
    input  wire logic i_chain_shift_out
);
    initial
    begin
        o_link_clock = 0;
        o_frame_select_n = 1;
        o_serial_data = 0;
    end
    task automatic send(input logic [47:0] w, input int n, output logic [23:0] echo);
        #7 o_frame_select_n = 0;
        for (int k = n - 1; k >= 0; k--)
        begin
            #5 o_serial_data = w[k];
            #10 o_link_clock = 1;
            #15 o_link_clock = 0;
            if (k < 24)
                echo = {echo[22:0], i_chain_shift_out};
        end
        #15 o_frame_select_n = 1;
        // released line must not hold the last bit
        o_serial_data = ~o_serial_data;
    endtask : send
endmodule : dcc_host_model

//--- tb/dcc_top_props.sv
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_top_props (
    input wire logic                              i_clock,
    input wire logic                              i_rst,
    input wire logic                              i_frame_select_n,
    input wire logic                              o_chain_shift_out,
    input wire logic                              i_interface_select,
    input wire logic                              i_chain_enable_pin,
    input wire logic                              i_load_outputs_strobe_n,
    input wire logic [`DCC_CHANNELS-1:0][`DCC_RES-1:0] o_dac_code,
    input wire logic                              o_write_accepted
);
    default clocking @(posedge i_clock); endclocking
    property p_rst_code; $fell(i_rst) |-> o_dac_code == '0; endproperty
    a_rst_code: assert property (p_rst_code) else $error("code not zero after reset");
    property p_rst_quiet; $fell(i_rst) |-> !o_write_accepted [*3]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("accept after reset");
    property p_pulse; disable iff (i_rst) o_write_accepted |=> !o_write_accepted; endproperty
    a_pulse: assert property (p_pulse) else $error("accept pulse too long");
    property p_hold;
        disable iff (i_rst) i_load_outputs_strobe_n [*6] |-> $stable(o_dac_code);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved without load");
    property p_quiet;
        disable iff (i_rst) !i_load_outputs_strobe_n [*6] ##0 !$past(o_write_accepted)
            |-> $stable(o_dac_code);
    endproperty
    a_quiet: assert property (p_quiet) else $error("code moved without write");
    property p_i2c; disable iff (i_rst) !i_interface_select [*8] |-> !o_write_accepted; endproperty
    a_i2c: assert property (p_i2c) else $error("write taken in other mode");
    property p_chain_off; disable iff (i_rst) !i_chain_enable_pin |-> !o_chain_shift_out; endproperty
    a_chain_off: assert property (p_chain_off) else $error("chain out active");
    property p_commit;
        disable iff (i_rst) o_write_accepted && i_chain_enable_pin |-> $past(i_frame_select_n, 2);
    endproperty
    a_commit: assert property (p_commit) else $error("chain write before frame end");
endmodule : dcc_top_props

//--- tb/dcc_top_tb.sv
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_top_tb;
    logic        i_clock = 0, i_rst = 1, i_interface_select = 1, i_chain_enable_pin = 0;
    logic        i_load_outputs_strobe_n = 0, link_clock, frame_n, sdata, chain_out, accepted;
    logic [`DCC_CHANNELS-1:0][`DCC_RES-1:0] dac_code;
    logic [31:0] rnd = 32'h0000000f;
    logic [23:0] echo;
    int          err_count = 0, check_count = 0, cycles = 0, n, due = 0;
    int          gain[16], offs[16], pend[16], act[16], q[$];
    always #4 i_clock = ~i_clock;
    dcc_top dcc_top_inst (.i_clock, .i_rst, .i_link_clock(link_clock), .i_frame_select_n(frame_n),
        .i_serial_data(sdata), .o_chain_shift_out(chain_out), .i_interface_select,
        .i_chain_enable_pin, .i_load_outputs_strobe_n, .o_dac_code(dac_code),
        .o_write_accepted(accepted));
    dcc_host_model dcc_host_model_inst (.o_link_clock(link_clock), .o_frame_select_n(frame_n),
        .o_serial_data(sdata), .i_chain_shift_out(chain_out));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return int'(rnd[13:0]);
    endfunction : xs
    function automatic int calc(int x, int m, int c);
        int s = ((m + 2) * x >> 14) + c - 8192;
        return s < 0 ? 0 : (s > 16383 ? 16383 : s);
    endfunction : calc
    task automatic chk(string nm, int e, logic [23:0] g);
        check_count++;
        if (g !== e[23:0])
        begin
            err_count++;
            $display("wrong value %s exp %h got %h", nm, e[23:0], g);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic wr(int ch, logic [1:0] sel, int d, logic [1:0] fl = 2'b00);
        dcc_pkg::dcc_cmd_t c;
        @(posedge i_clock);
        c = {fl, 2'b00, ch[3:0], sel, d[13:0]};
        if (fl == 0 && i_interface_select && sel != dcc_pkg::DCC_SEL_SPECIAL)
        begin
            if (sel == dcc_pkg::DCC_SEL_OFFSET) offs[ch] = d & 16'h3fff;
            if (sel == dcc_pkg::DCC_SEL_GAIN) gain[ch] = d & 16'h3ffe;
            if (sel == dcc_pkg::DCC_SEL_INPUT) pend[ch] = calc(d & 16'h3fff, gain[ch], offs[ch]);
            if (!i_load_outputs_strobe_n) act[ch] = pend[ch];
            q.push_back(ch * 65536 + act[ch]);
        end
        dcc_host_model_inst.send({24'h0, c}, 24, echo);
        repeat (12) @(posedge i_clock);
    endtask : wr
    task automatic rst_dut(logic chain);
        i_rst <= 1;
        i_chain_enable_pin <= chain;
        repeat (20) @(posedge i_clock);
        foreach (gain[i])
        begin
            gain[i] = 16'h3ffe;
            offs[i] = 16'h2000;
            pend[i] = 0;
            act[i] = 0;
        end
        i_rst <= 0;
        repeat (3) @(posedge i_clock);
        foreach (act[i]) chk("reset code", 0, dac_code[i]);
    endtask : rst_dut
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    // the code follows pending one cycle after the accept pulse, so look then
    always @(negedge i_clock)
    begin
        if (due)
            chk("dac code", n % 65536, dac_code[n / 65536]);
        due = 0;
        if (accepted === 1'b1)
        begin
            n = q.size() ? q.pop_front() : -1;
            if (n < 0) chk("accept", 0, 1);
            else due = 1;
        end
    end
    initial
    begin
        rst_dut(0);
        wr(3, 3, 16'h1234);
        wr(3, 1, 16'h1fff);
        wr(3, 3, 16'h3000);
        wr(3, 2, 16'h3fff);
        wr(3, 3, 16'h3000);
        wr(3, 1, 16'h3ffe);
        wr(3, 3, 16'h3fff);
        wr(3, 2, 0);
        wr(3, 3, 16'h0100);
        $display("test calibration done");
        repeat (40) wr(xs() % 16, xs() % 3 + 1, xs());
        $display("test random done");
        wr(5, 3, 16'h0abc, 2'b01);
        wr(5, 3, 16'h0abc, 2'b10);
        wr(5, 0, 16'h0abc);
        dcc_host_model_inst.send(48'h00f3ffff, 20, echo);
        i_interface_select <= 0;
        wr(6, 3, 16'h0aaa);
        i_interface_select <= 1;
        $display("test refused done");
        i_load_outputs_strobe_n <= 1;
        wr(7, 3, 16'h0555);
        wr(8, 3, 16'h0666);
        i_load_outputs_strobe_n <= 0;
        repeat (6) @(posedge i_clock);
        chk("load 7", pend[7], dac_code[7]);
        chk("load 8", pend[8], dac_code[8]);
        $display("test load done");
        rst_dut(1);
        q.push_back(2 * 65536 + 16'h0777);
        dcc_host_model_inst.send({24'h03c123, 24'h02c777}, 48, echo);
        repeat (12) @(posedge i_clock);
        chk("chain echo", 24'h03c123, echo);
        chk("chain drop", 0, dac_code[3]);
        $display("test chain done");
        stop_test();
    end
endmodule : dcc_top_tb
bind dcc_top dcc_top_props dcc_top_props_inst (.i_clock, .i_rst, .i_frame_select_n,
    .o_chain_shift_out, .i_interface_select, .i_chain_enable_pin, .i_load_outputs_strobe_n,
    .o_dac_code, .o_write_accepted);
